// >>> core/clock_divider.sv
`timescale 1ns/10ps
`default_nettype none

module clock_divider #(
  parameter int DIV = 4
) (
  input  wire logic i_core_clk,
  input  wire logic i_rst_n,
  input  wire logic i_ce,
  output var  logic o_clk
);

  localparam logic [7:0] HALF = 8'(DIV / 2 - 1);

  logic [7:0] cnt;

  if (DIV < 2 || DIV % 2 != 0 || DIV > 510) begin : g_bad_div
    $error("clock_divider needs an even DIV from 2 to 510");
  end

  // even division keeps a 50 percent duty cycle
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt   <= 8'h00;
      o_clk <= 1'b0;
    end else if (i_ce) begin
      if (cnt == HALF) begin
        cnt   <= 8'h00;
        o_clk <= ~o_clk;
      end else begin
        cnt <= cnt + 8'h01;
      end
    end
  end

endmodule

`default_nettype wire

// >>> core/level_sync.sv
`timescale 1ns/10ps
`default_nettype none

module level_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             i_core_clk,
  input  wire logic             i_rst_n,
  input  wire logic             i_ce,
  input  wire logic [WIDTH-1:0] i_d,
  output var  logic [WIDTH-1:0] o_q
);

  logic [WIDTH-1:0] meta;

  if (WIDTH < 1) begin : g_bad_width
    $error("level_sync needs WIDTH of at least 1");
  end

  // first stage feeds only the second
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta <= '0;
      o_q  <= '0;
    end else if (i_ce) begin
      meta <= i_d;
      o_q  <= meta;
    end
  end

endmodule

`default_nettype wire

// >>> core/pin_mux_pkg.sv
package pin_mux_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses, one word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] GPIO_EN_OFS    = 8'h00;
  localparam logic [7:0] GPIO_DIR_OFS   = 8'h04;
  localparam logic [7:0] STRAP_OFS      = 8'h08;
  localparam logic [7:0] PIN_LEVEL_OFS  = 8'h0C;

  // ----------------------------------------------------------------
  // reset values and pin groups
  // ----------------------------------------------------------------
  localparam logic [15:0] GPIO_EN_RST   = 16'h0000;
  localparam logic [15:0] GPIO_DIR_RST  = 16'h0000;
  localparam logic [15:0] SW_MUX_MASK   = 16'h0106;
  localparam logic [15:0] PCI_MUX_MASK  = 16'hFE00;
  localparam int          PIN_QUARTER   = 1;
  localparam int          PIN_SIXTH     = 2;
  localparam int          PIN_SERIAL2   = 8;

  // ----------------------------------------------------------------
  // strap status field positions
  // ----------------------------------------------------------------
  localparam int STRAP_PCI_BIT    = 0;
  localparam int STRAP_UTOPIA_BIT = 1;
  localparam int STRAP_WIDTH_BIT  = 2;
  localparam int STRAP_VALID_BIT  = 3;

  // ----------------------------------------------------------------
  // cycle counts
  // ----------------------------------------------------------------
  localparam int         QUARTER_DIV  = 4;
  localparam int         SIXTH_DIV    = 6;
  localparam logic [1:0] STRAP_SETTLE = 2'h2;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic pci_select;
    logic utopia_select;
    logic host_width;
  } strap_t;

  localparam strap_t STRAP_RST = '0;

endpackage

// >>> core/shared_pin_function_select.sv
// The register offsets and the Wishbone register port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none

module shared_pin_function_select #(
  parameter bit HAS_PCI_UTOPIA = 1'b1,
  parameter int PINS           = 16
) (
  input  wire logic                   i_core_clk,
  input  wire logic                   i_rst_n,
  input  wire logic                   i_ce,
  input  wire pin_mux_pkg::wb_req_t   i_wb,
  output var  logic                   o_wb_ack,
  output var  logic [31:0]            o_wb_dat,
  input  wire logic                   i_pci_select_strap,
  input  wire logic                   i_utopia_select_strap,
  input  wire logic                   i_host_width_strap,
  input  wire logic [PINS-1:0]        i_pin_in,
  input  wire logic [PINS-1:0]        i_gpio_dout,
  output var  logic [PINS-1:0]        o_pin_out,
  output var  logic [PINS-1:0]        o_pin_oe,
  output var  logic [PINS-1:0]        o_gpio_sel,
  output var  logic [PINS-1:0]        o_gpio_din,
  output var  logic                   o_serial2_ext_clock_in,
  output var  logic                   o_pci_owns,
  output var  logic                   o_host_owns,
  output var  logic                   o_utopia_owns,
  output var  logic                   o_serial1_owns,
  output var  logic                   o_host_width32,
  output var  logic                   o_host_halfword_active,
  output var  logic                   o_host_upper_hiz,
  output var  logic                   o_pci_standalone_hiz,
  output var  logic                   o_utopia_standalone_hiz,
  output var  logic                   o_straps_valid
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  localparam logic [15:0] EN_MASK = HAS_PCI_UTOPIA ?
                                    (pin_mux_pkg::SW_MUX_MASK | pin_mux_pkg::PCI_MUX_MASK) :
                                    pin_mux_pkg::SW_MUX_MASK;

  logic [15:0]                gpio_en;
  logic [15:0]                gpio_dir;
  logic [15:0]                gpio_active;
  logic [15:0]                next_pin_out;
  logic [15:0]                next_pin_oe;
  logic [15:0]                pin_sync;
  logic [2:0]                 strap_sync;
  logic [1:0]                 settle_cnt;
  logic                       quarter_clk;
  logic                       sixth_clk;
  logic                       wb_req;
  logic                       wb_wr;
  logic [31:0]                next_rd_dat;
  logic [15:0]                wr_lanes;
  pin_mux_pkg::strap_t        straps;

  if (PINS != 16) begin : g_bad_pins
    $error("shared_pin_function_select serves exactly 16 pins");
  end

  // ----------------------------------------------------------------
  // input synchronisers and clock sources
  // ----------------------------------------------------------------
  level_sync #(
    .WIDTH (16)
  ) u_pin_sync (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_ce       (i_ce),
    .i_d        (i_pin_in),
    .o_q        (pin_sync)
  );

  level_sync #(
    .WIDTH (3)
  ) u_strap_sync (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_ce       (i_ce),
    .i_d        ({i_pci_select_strap, i_utopia_select_strap, i_host_width_strap}),
    .o_q        (strap_sync)
  );

  clock_divider #(
    .DIV (pin_mux_pkg::QUARTER_DIV)
  ) u_quarter_div (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_ce       (i_ce),
    .o_clk      (quarter_clk)
  );

  clock_divider #(
    .DIV (pin_mux_pkg::SIXTH_DIV)
  ) u_sixth_div (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_ce       (i_ce),
    .o_clk      (sixth_clk)
  );

  // ----------------------------------------------------------------
  // strap capture
  // ----------------------------------------------------------------
  // the synchroniser is still flushing its reset value for two edges,
  // so the straps are taken only once it holds the real pin levels
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      settle_cnt     <= 2'h0;
      straps         <= pin_mux_pkg::STRAP_RST;
      o_straps_valid <= 1'b0;
    end else if (i_ce && !o_straps_valid) begin
      if (settle_cnt == pin_mux_pkg::STRAP_SETTLE) begin
        straps.pci_select    <= HAS_PCI_UTOPIA && strap_sync[2];
        straps.utopia_select <= HAS_PCI_UTOPIA && strap_sync[1];
        straps.host_width    <= strap_sync[0];
        o_straps_valid       <= 1'b1;
      end else begin
        settle_cnt <= settle_cnt + 2'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // peripheral ownership
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pci_owns              <= 1'b0;
      o_host_owns             <= 1'b1;
      o_utopia_owns           <= 1'b0;
      o_serial1_owns          <= 1'b1;
      o_host_width32          <= 1'b0;
      o_host_halfword_active  <= 1'b1;
      o_host_upper_hiz        <= 1'b1;
      o_pci_standalone_hiz    <= 1'b1;
      o_utopia_standalone_hiz <= 1'b1;
    end else if (i_ce) begin
      o_pci_owns              <= straps.pci_select;
      o_host_owns             <= !straps.pci_select;
      o_utopia_owns           <= straps.utopia_select;
      o_serial1_owns          <= !straps.utopia_select;
      o_host_width32          <= !straps.pci_select && straps.host_width;
      o_host_halfword_active  <= !straps.pci_select && !straps.host_width;
      o_host_upper_hiz        <= !straps.pci_select && !straps.host_width;
      o_pci_standalone_hiz    <= !straps.pci_select;
      o_utopia_standalone_hiz <= !straps.utopia_select;
    end
  end

  // ----------------------------------------------------------------
  // per-pin function select
  // ----------------------------------------------------------------
  for (genvar g = 0; g < 16; g++) begin : g_pin
    assign gpio_active[g]  = gpio_en[g] && !(pin_mux_pkg::PCI_MUX_MASK[g] && straps.pci_select);
    assign next_pin_oe[g]  = gpio_active[g] ? gpio_dir[g] :
                             (g == pin_mux_pkg::PIN_QUARTER || g == pin_mux_pkg::PIN_SIXTH);
    assign next_pin_out[g] = gpio_active[g] ? (gpio_dir[g] && i_gpio_dout[g]) :
                             (g == pin_mux_pkg::PIN_QUARTER) ? quarter_clk :
                             (g == pin_mux_pkg::PIN_SIXTH)   ? sixth_clk : 1'b0;
  end

  // outputs are registered, so a write shows at the pins one edge later
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pin_out              <= '0;
      o_pin_oe               <= '0;
      o_gpio_sel             <= '0;
      o_gpio_din             <= '0;
      o_serial2_ext_clock_in <= 1'b0;
    end else if (i_ce) begin
      o_pin_out              <= next_pin_out;
      o_pin_oe               <= next_pin_oe;
      o_gpio_sel             <= gpio_active;
      o_gpio_din             <= pin_sync & gpio_active & ~gpio_dir;
      o_serial2_ext_clock_in <= pin_sync[pin_mux_pkg::PIN_SERIAL2] &&
                                !gpio_active[pin_mux_pkg::PIN_SERIAL2];
    end
  end

  // ----------------------------------------------------------------
  // wishbone slave
  // ----------------------------------------------------------------
  assign wb_req   = i_wb.cyc && i_wb.stb && !o_wb_ack;
  assign wb_wr    = wb_req && i_wb.we;
  assign wr_lanes = {{8{i_wb.sel[1]}}, {8{i_wb.sel[0]}}};

  always_comb begin
    next_rd_dat = 32'h0000_0000;
    unique case (i_wb.adr)
      pin_mux_pkg::GPIO_EN_OFS:   next_rd_dat[15:0] = gpio_en;
      pin_mux_pkg::GPIO_DIR_OFS:  next_rd_dat[15:0] = gpio_dir;
      pin_mux_pkg::STRAP_OFS: begin
        next_rd_dat[pin_mux_pkg::STRAP_PCI_BIT]    = straps.pci_select;
        next_rd_dat[pin_mux_pkg::STRAP_UTOPIA_BIT] = straps.utopia_select;
        next_rd_dat[pin_mux_pkg::STRAP_WIDTH_BIT]  = straps.host_width;
        next_rd_dat[pin_mux_pkg::STRAP_VALID_BIT]  = o_straps_valid;
      end
      pin_mux_pkg::PIN_LEVEL_OFS: next_rd_dat[15:0] = pin_sync;
      default:                    next_rd_dat = 32'h0000_0000;
    endcase
  end

  // every access, mapped or not, is answered one edge after it is seen
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
    end else if (i_ce) begin
      o_wb_ack <= wb_req;
      o_wb_dat <= (wb_req && !i_wb.we) ? next_rd_dat : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // gpio enable and direction registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      gpio_en <= pin_mux_pkg::GPIO_EN_RST;
    end else if (i_ce && wb_wr && i_wb.adr == pin_mux_pkg::GPIO_EN_OFS) begin
      gpio_en <= ((i_wb.dat[15:0] & wr_lanes) | (gpio_en & ~wr_lanes)) & EN_MASK;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      gpio_dir <= pin_mux_pkg::GPIO_DIR_RST;
    end else if (i_ce && wb_wr && i_wb.adr == pin_mux_pkg::GPIO_DIR_OFS) begin
      gpio_dir <= ((i_wb.dat[15:0] & wr_lanes) | (gpio_dir & ~wr_lanes)) & EN_MASK;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  logic seen_edge;

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      seen_edge <= 1'b0;
    end else begin
      seen_edge <= 1'b1;
    end
  end

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_n);

  a_en_after_reset: assert property (!seen_edge |-> gpio_en == 16'h0000)
    else $error("gpio enable not clear after reset");

  // two ce edges: one loads the enable, one registers the pin
  a_sw_mux_live: assert property (
    (i_ce && wb_wr && i_wb.adr == pin_mux_pkg::GPIO_EN_OFS && i_wb.sel[0] && i_wb.dat[1]) ##1 i_ce
    |=> o_gpio_sel[1])
    else $error("pin 1 did not follow enable write");

  a_clock_default: assert property (
    (i_ce && !gpio_en[1]) |=> (o_pin_oe[1] && o_pin_out[1] == $past(quarter_clk)))
    else $error("pin 1 not carrying quarter clock");

  a_gpio_output: assert property (
    (i_ce && gpio_en[2] && gpio_dir[2]) |=> (o_pin_oe[2] && o_pin_out[2] == $past(i_gpio_dout[2])))
    else $error("enabled output pin not driven");

  a_gpio_input: assert property (
    (i_ce && gpio_en[8] && !gpio_dir[8]) |=> (!o_pin_oe[8] && !o_serial2_ext_clock_in))
    else $error("enabled input pin driven");

  a_pci_blocks: assert property (
    (i_ce && straps.pci_select) |=> (o_pin_oe[15:9] == 7'h00 && o_gpio_sel[15:9] == 7'h00))
    else $error("gpio active on pci pins");

  a_straps_hold: assert property (o_straps_valid && $past(o_straps_valid) |-> $stable(straps))
    else $error("strap select changed after capture");

  a_single_owner: assert property (
    (o_pci_owns != o_host_owns) && (o_utopia_owns != o_serial1_owns))
    else $error("two peripherals own one pin group");

  a_width_hiz: assert property (o_host_upper_hiz |-> (!o_host_width32 && o_host_owns))
    else $error("upper host data high-Z while 32-bit");

  a_variant: assert property (!HAS_PCI_UTOPIA |-> (!o_pci_owns && !o_utopia_owns))
    else $error("variant without pci owns pci pins");

  // a bus answer stands one cycle only
  a_ack_single: assert property ((i_ce && o_wb_ack) |=> !o_wb_ack)
    else $error("bus ack held longer than one cycle");

  a_idle_pci_pins: assert property (
    (i_ce && gpio_en[15:9] == 7'h00) |=> (o_pin_oe[15:9] == 7'h00))
    else $error("disabled pci group pin driven");

  a_serial1_default: assert property (
    (i_ce && !straps.utopia_select) |=> (o_serial1_owns && !o_utopia_owns))
    else $error("serial port one lost its pins");

  a_pci_hiz: assert property (
    (i_ce && !straps.pci_select) |=> (o_pci_standalone_hiz && o_host_owns))
    else $error("pci pins not high-Z while pci off");

  a_utopia_hiz: assert property (
    (i_ce && !straps.utopia_select) |=> o_utopia_standalone_hiz)
    else $error("utopia pins not high-Z while utopia off");

  a_fixed_pins: assert property (
    o_pin_oe[7:3] == 5'h00 && !o_pin_oe[0] && o_gpio_sel[7:3] == 5'h00 && !o_gpio_sel[0])
    else $error("unshared pin taken over");

  a_halfword_host: assert property (o_host_halfword_active |-> (o_host_owns && !o_host_width32))
    else $error("halfword select active outside 16-bit host mode");

  c_pin_output:   cover property (o_gpio_sel[1] && o_pin_oe[1]);
  c_pci_captured: cover property ($rose(o_straps_valid) ##1 o_pci_owns);
  c_utopia_owns:  cover property (o_utopia_owns && o_straps_valid);
  c_bus_write:    cover property (wb_wr ##1 o_wb_ack);
  c_gpio_input:   cover property (o_gpio_sel[8] && !o_pin_oe[8]);

endmodule

`default_nettype wire

// >>> tb/shared_pin_function_select_tb.sv
`timescale 1ns/10ps
`default_nettype none

`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("wrong value %s expected %h seen %h", nm, (exp), (got)); end end

module shared_pin_function_select_tb;

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] en;
    logic [15:0] dir;
    logic [15:0] sel;
    logic [15:0] oe;
  } row_t;

  logic                 core_clk;
  logic                 rst_n;
  logic                 ce;
  pin_mux_pkg::wb_req_t wb;
  logic                 wb_ack;
  logic [31:0]          wb_dat;
  logic                 pci_strap;
  logic                 utopia_strap;
  logic                 width_strap;
  logic [15:0]          pin_in;
  logic [15:0]          gpio_dout;
  logic [15:0]          pin_out;
  logic [15:0]          pin_oe;
  logic [15:0]          gpio_sel;
  logic [15:0]          gpio_din;
  logic                 serial2_clk;
  logic                 pci_owns;
  logic                 host_owns;
  logic                 utopia_owns;
  logic                 serial1_owns;
  logic                 width32;
  logic                 halfword;
  logic                 upper_hiz;
  logic                 pci_hiz;
  logic                 utopia_hiz;
  logic                 straps_valid;
  int                   n_mismatch;
  int                   checked;
  int                   cycles;
  logic [31:0]          rd;
  logic [15:0]          exp_sel;
  logic                 a;
  logic                 b;
  logic                 c;
  row_t                 rows [5];
  logic [15:0]          lite_sel;
  logic                 lite_pci;
  logic                 lite_utopia;

  shared_pin_function_select DUT (
    .i_core_clk              (core_clk),
    .i_rst_n                 (rst_n),
    .i_ce                    (ce),
    .i_wb                    (wb),
    .o_wb_ack                (wb_ack),
    .o_wb_dat                (wb_dat),
    .i_pci_select_strap      (pci_strap),
    .i_utopia_select_strap   (utopia_strap),
    .i_host_width_strap      (width_strap),
    .i_pin_in                (pin_in),
    .i_gpio_dout             (gpio_dout),
    .o_pin_out               (pin_out),
    .o_pin_oe                (pin_oe),
    .o_gpio_sel              (gpio_sel),
    .o_gpio_din              (gpio_din),
    .o_serial2_ext_clock_in  (serial2_clk),
    .o_pci_owns              (pci_owns),
    .o_host_owns             (host_owns),
    .o_utopia_owns           (utopia_owns),
    .o_serial1_owns          (serial1_owns),
    .o_host_width32          (width32),
    .o_host_halfword_active  (halfword),
    .o_host_upper_hiz        (upper_hiz),
    .o_pci_standalone_hiz    (pci_hiz),
    .o_utopia_standalone_hiz (utopia_hiz),
    .o_straps_valid          (straps_valid)
  );

  // variant without pci and utopia, on the same bus and pins as DUT
  shared_pin_function_select #(
    .HAS_PCI_UTOPIA (1'b0)
  ) DUT_lite (
    .i_core_clk              (core_clk),
    .i_rst_n                 (rst_n),
    .i_ce                    (ce),
    .i_wb                    (wb),
    .o_wb_ack                (),
    .o_wb_dat                (),
    .i_pci_select_strap      (pci_strap),
    .i_utopia_select_strap   (utopia_strap),
    .i_host_width_strap      (width_strap),
    .i_pin_in                (pin_in),
    .i_gpio_dout             (gpio_dout),
    .o_pin_out               (),
    .o_pin_oe                (),
    .o_gpio_sel              (lite_sel),
    .o_gpio_din              (),
    .o_serial2_ext_clock_in  (),
    .o_pci_owns              (lite_pci),
    .o_host_owns             (),
    .o_utopia_owns           (lite_utopia),
    .o_serial1_owns          (),
    .o_host_width32          (),
    .o_host_halfword_active  (),
    .o_host_upper_hiz        (),
    .o_pci_standalone_hiz    (),
    .o_utopia_standalone_hiz (),
    .o_straps_valid          ()
  );

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // hang guard: the whole sequence needs about two hundred cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 2000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  // classic cycle: hold until ack is sampled, then idle one cycle
  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    wb <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF, dat: dat};
    do begin
      @(posedge core_clk);
    end while (wb_ack !== 1'b1);
    rd = wb_dat;
    wb <= '0;
    @(posedge core_clk);
  endtask

  // straps stay steady well past the capture point
  task automatic do_reset(input logic p, input logic u, input logic w);
    rst_n <= 1'b0;
    pci_strap <= p;
    utopia_strap <= u;
    width_strap <= w;
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge core_clk);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    wb = '0;
    pci_strap = 1'b0;
    utopia_strap = 1'b0;
    width_strap = 1'b1;
    pin_in = 16'h5B5A;
    gpio_dout = 16'hA5A5;
    n_mismatch = 0;
    checked = 0;
    cycles = 0;
    rows[0] = '{en: 16'hFFFF, dir: 16'h0000, sel: 16'hFF06, oe: 16'h0000};
    rows[1] = '{en: 16'hFFFF, dir: 16'hFFFF, sel: 16'hFF06, oe: 16'hFF06};
    rows[2] = '{en: 16'h0106, dir: 16'h0004, sel: 16'h0106, oe: 16'h0004};
    rows[3] = '{en: 16'h0000, dir: 16'hFFFF, sel: 16'h0000, oe: 16'h0006};
    rows[4] = '{en: 16'hFE00, dir: 16'hAA00, sel: 16'hFE00, oe: 16'hAA06};
    do_reset(1'b0, 1'b0, 1'b1);

    `CHK("pin_oe", 16'h0006, pin_oe)
    `CHK("gpio_sel", 16'h0000, gpio_sel)
    `CHK("host group", 6'h19, {pci_owns, host_owns, width32, halfword, upper_hiz, pci_hiz})
    `CHK("utopia group", 3'h3, {utopia_owns, serial1_owns, utopia_hiz})
    wb_xfer(1'b0, 8'h00, 32'h0000_0000);
    `CHK("enable reg", 32'h0000_0000, rd)
    wb_xfer(1'b0, 8'h08, 32'h0000_0000);
    `CHK("strap reg", 32'h0000_000C, rd)
    $display("reset defaults done");

    // default clock outputs: quarter toggles every 2, sixth every 3
    a = pin_out[1];
    repeat (2) @(posedge core_clk);
    b = pin_out[1];
    repeat (2) @(posedge core_clk);
    c = pin_out[1];
    `CHK("quarter half", ~a, b)
    `CHK("quarter full", a, c)
    a = pin_out[2];
    repeat (3) @(posedge core_clk);
    b = pin_out[2];
    repeat (3) @(posedge core_clk);
    c = pin_out[2];
    `CHK("sixth half", ~a, b)
    `CHK("sixth full", a, c)
    // with ce low the divider must not move for six edges
    ce <= 1'b0;
    @(posedge core_clk);
    a = pin_out[1];
    repeat (6) @(posedge core_clk);
    `CHK("frozen quarter", a, pin_out[1])
    ce <= 1'b1;
    $display("divider test done");

    // software mux rows, rewritten at run time in both directions
    foreach (rows[i]) begin
      wb_xfer(1'b1, 8'h00, {16'h0000, rows[i].en});
      wb_xfer(1'b1, 8'h04, {16'h0000, rows[i].dir});
      repeat (4) @(posedge core_clk);
      exp_sel = rows[i].sel;
      `CHK("gpio_sel", exp_sel, gpio_sel)
      `CHK("lite gpio_sel", rows[i].en & 16'h0106, lite_sel)
      `CHK("pin_oe", rows[i].oe, pin_oe)
      `CHK("pin_out", gpio_dout & exp_sel & rows[i].dir, pin_out & exp_sel & rows[i].dir)
      `CHK("gpio_din", pin_in & exp_sel & ~rows[i].dir, gpio_din)
      `CHK("serial2", pin_in[8] & ~exp_sel[8], serial2_clk)
      wb_xfer(1'b0, 8'h00, 32'h0000_0000);
      `CHK("enable reg", {16'h0000, exp_sel}, rd)
      wb_xfer(1'b0, 8'h04, 32'h0000_0000);
      `CHK("dir reg", {16'h0000, rows[i].dir & 16'hFF06}, rd)
      $display("row %0d done", i);
    end

    // unmapped and read-only places leave everything alone
    wb_xfer(1'b1, 8'h10, 32'hFFFF_FFFF);
    wb_xfer(1'b1, 8'h08, 32'h0000_0000);
    wb_xfer(1'b0, 8'h10, 32'h0000_0000);
    `CHK("unmapped", 32'h0000_0000, rd)
    wb_xfer(1'b0, 8'h00, 32'h0000_0000);
    `CHK("enable reg", 32'h0000_FE00, rd)
    wb_xfer(1'b0, 8'h08, 32'h0000_0000);
    `CHK("strap reg", 32'h0000_000C, rd)

    // strap pins moving after reset must not move ownership
    pci_strap <= 1'b1;
    utopia_strap <= 1'b1;
    width_strap <= 1'b0;
    repeat (8) @(posedge core_clk);
    `CHK("host group", 6'h19, {pci_owns, host_owns, width32, halfword, upper_hiz, pci_hiz})
    `CHK("utopia group", 3'h3, {utopia_owns, serial1_owns, utopia_hiz})
    $display("strap hold done");

    // second reset in mid-run with every strap flipped
    do_reset(1'b1, 1'b1, 1'b0);
    `CHK("host group", 6'h20, {pci_owns, host_owns, width32, halfword, upper_hiz, pci_hiz})
    `CHK("utopia group", 3'h4, {utopia_owns, serial1_owns, utopia_hiz})
    `CHK("straps_valid", 1'b1, straps_valid)
    `CHK("lite owners", 2'h0, {lite_pci, lite_utopia})
    wb_xfer(1'b0, 8'h08, 32'h0000_0000);
    `CHK("strap reg", 32'h0000_000B, rd)
    wb_xfer(1'b1, 8'h00, 32'h0000_FFFF);
    wb_xfer(1'b1, 8'h04, 32'h0000_FFFF);
    repeat (4) @(posedge core_clk);
    `CHK("gpio_sel", 16'h0106, gpio_sel)
    `CHK("pin_oe", 16'h0106, pin_oe)
    `CHK("lite gpio_sel", 16'h0106, lite_sel)
    wb_xfer(1'b0, 8'h00, 32'h0000_0000);
    `CHK("enable reg", 32'h0000_FF06, rd)
    $display("pci strap test done");

    end_of_test();
  end

endmodule

`default_nettype wire
